//--- hw/clkgate_regs.sv
// Purpose: set/clear clock gating registers behind an Avalon-MM slave
// Assumes: one clock, synchronous active-low reset, one wait state per read
// Notes: writes take no wait state; read data come straight from a flop
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
module clkgate_regs
    import clkgate_pkg::*;
#(
    parameter logic [31:0] PERIPH_IMPL = 32'hffff_fffc
)
(
    input  wire logic               ref_clk,
    input  wire logic               resetn,
    input  wire logic [7:0]         avs_address,
    input  wire logic               avs_read,
    input  wire logic               avs_write,
    input  wire logic [31:0]        avs_writedata,
    input  wire logic [3:0]         avs_byteenable,
    output logic      [31:0]        avs_readdata,
    output logic                    avs_waitrequest,
    output logic      [1:0]         avs_response,
    output var clkgate_sys_gates_s  sys_gates,
    output logic      [31:0]        periph_clk_en
);
    logic [31:0] sys_state_reg, sys_state_next;
    logic [31:0] per_state_reg, per_state_next;
    logic [31:0] utmi_reg, osc_reg, plla_reg, mck_reg, usb_reg, smd_reg;
    logic [31:0] prog0_reg, prog1_reg, icp_reg, wpm_reg;
    logic [31:0] rdata_next;
    logic        rd_pend_reg;
    logic [31:0] rdata_reg;

    // byte-enable merge; full word writes are expected
    function automatic logic [31:0] be_mask(input logic [3:0] be);
        be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  be);
        merge = (old_v & ~be_mask(be)) | (new_v & be_mask(be));
    endfunction

    wire logic [31:0] wdata_m   = avs_writedata & be_mask(avs_byteenable);
    wire logic        wr_sysset = avs_write && avs_address == OFS_SYS_SET;
    wire logic        wr_sysclr = avs_write && avs_address == OFS_SYS_CLR;
    wire logic        wr_perset = avs_write && avs_address == OFS_PER_SET;
    wire logic        wr_perclr = avs_write && avs_address == OFS_PER_CLR;
    // zero bits are no-ops; masks keep unused bits out
    wire logic [31:0] sys_set_v = wr_sysset ? (wdata_m & SYS_SET_MASK) : RST_ZERO;
    wire logic [31:0] sys_clr_v = wr_sysclr ? (wdata_m & SYS_CLR_MASK) : RST_ZERO;
    wire logic [31:0] per_set_v = wr_perset ? (wdata_m & PER_ID_MASK & PERIPH_IMPL)
                                            : RST_ZERO;
    wire logic [31:0] per_clr_v = wr_perclr ? (wdata_m & PER_ID_MASK & PERIPH_IMPL)
                                            : RST_ZERO;

    assign sys_state_next = (sys_state_reg | sys_set_v) & ~sys_clr_v;
    assign per_state_next = (per_state_reg | per_set_v) & ~per_clr_v;

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            sys_state_reg <= RST_SYS_STATE;
            per_state_reg <= RST_PER_STATE;
        end
        else
        begin
            sys_state_reg <= sys_state_next;
            per_state_reg <= per_state_next;
        end
    end

    wire logic wr_utmi  = avs_write && avs_address == OFS_UTMI_CFG;
    wire logic wr_osc   = avs_write && avs_address == OFS_MAIN_OSC;
    wire logic wr_plla  = avs_write && avs_address == OFS_PLLA_CFG;
    wire logic wr_mck   = avs_write && avs_address == OFS_MCK_CFG;
    wire logic wr_usb   = avs_write && avs_address == OFS_USB_CFG;
    wire logic wr_smd   = avs_write && avs_address == OFS_SMD_CFG;
    wire logic wr_prog0 = avs_write && avs_address == OFS_PROG0_CFG;
    wire logic wr_prog1 = avs_write && avs_address == OFS_PROG1_CFG;
    wire logic wr_icp   = avs_write && avs_address == OFS_PLL_ICP;
    wire logic wr_wpm   = avs_write && avs_address == OFS_WP_MODE;

    // plain storage only; field semantics live elsewhere
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            utmi_reg  <= RST_UTMI_CFG;
            osc_reg   <= RST_MAIN_OSC;
            plla_reg  <= RST_PLLA_CFG;
            mck_reg   <= RST_MCK_CFG;
            usb_reg   <= RST_ZERO;
            smd_reg   <= RST_ZERO;
            prog0_reg <= RST_ZERO;
            prog1_reg <= RST_ZERO;
            icp_reg   <= RST_PLL_ICP;
            wpm_reg   <= RST_ZERO;
        end
        else
        begin
            if (wr_utmi)  utmi_reg  <= merge(utmi_reg,  avs_writedata, avs_byteenable);
            if (wr_osc)   osc_reg   <= merge(osc_reg,   avs_writedata, avs_byteenable);
            if (wr_plla)  plla_reg  <= merge(plla_reg,  avs_writedata, avs_byteenable);
            if (wr_mck)   mck_reg   <= merge(mck_reg,   avs_writedata, avs_byteenable);
            if (wr_usb)   usb_reg   <= merge(usb_reg,   avs_writedata, avs_byteenable);
            if (wr_smd)   smd_reg   <= merge(smd_reg,   avs_writedata, avs_byteenable);
            if (wr_prog0) prog0_reg <= merge(prog0_reg, avs_writedata, avs_byteenable);
            if (wr_prog1) prog1_reg <= merge(prog1_reg, avs_writedata, avs_byteenable);
            if (wr_icp)   icp_reg   <= merge(icp_reg,   avs_writedata, avs_byteenable);
            if (wr_wpm)   wpm_reg   <= merge(wpm_reg,   avs_writedata, avs_byteenable);
        end
    end

    // read mux; write-only and reserved read zero
    always_comb
    begin
        case (avs_address)
            OFS_SYS_STATE:  rdata_next = sys_state_reg;
            OFS_PER_STATE:  rdata_next = per_state_reg;
            OFS_UTMI_CFG:   rdata_next = utmi_reg;
            OFS_MAIN_OSC:   rdata_next = osc_reg;
            OFS_MAIN_FREQ:  rdata_next = RST_ZERO;
            OFS_PLLA_CFG:   rdata_next = plla_reg;
            OFS_MCK_CFG:    rdata_next = mck_reg;
            OFS_USB_CFG:    rdata_next = usb_reg;
            OFS_SMD_CFG:    rdata_next = smd_reg;
            OFS_PROG0_CFG:  rdata_next = prog0_reg;
            OFS_PROG1_CFG:  rdata_next = prog1_reg;
            OFS_PWR_STATUS: rdata_next = RST_PWR_STATUS;
            OFS_IRQ_MASK:   rdata_next = RST_ZERO;
            OFS_WP_MODE:    rdata_next = wpm_reg;
            OFS_WP_STATUS:  rdata_next = RST_ZERO;
            default:        rdata_next = RST_ZERO;
        endcase
    end

    // first read cycle stalls so readdata can come from a flop
    wire logic rd_first = avs_read && !rd_pend_reg;

    // one wait state costs bandwidth but keeps the read path registered
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            rd_pend_reg <= 1'b0;
            rdata_reg   <= RST_ZERO;
        end
        else
        begin
            rd_pend_reg <= rd_first;
            rdata_reg   <= rd_first ? rdata_next : rdata_reg;
        end
    end

    assign avs_readdata    = rdata_reg;
    assign avs_waitrequest = rd_first;
    assign avs_response    = 2'b00;

    assign sys_gates.cpu            = sys_state_reg[BIT_CPU];
    assign sys_gates.ddr            = sys_state_reg[BIT_DDR];
    assign sys_gates.smd            = sys_state_reg[BIT_SMD];
    assign sys_gates.usb_host_48mhz = sys_state_reg[BIT_UHP];
    assign sys_gates.usb_host_12mhz = sys_state_reg[BIT_UHP];
    assign sys_gates.usb_dev        = sys_state_reg[BIT_UDP];
    assign sys_gates.prog_out0      = sys_state_reg[BIT_PROG0];
    assign sys_gates.prog_out1      = sys_state_reg[BIT_PROG1];
    assign periph_clk_en            = per_state_reg;

    ddr_set_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        wr_sysset && avs_writedata[BIT_DDR] && avs_byteenable[0] && !wr_sysclr
        |=> sys_gates.ddr)
        else $error("ddr set lost");

    ddr_clr_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        wr_sysclr && avs_writedata[BIT_DDR] && avs_byteenable[0] |=> !sys_gates.ddr)
        else $error("ddr clear lost");

    smd_set_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        wr_sysset && avs_writedata[BIT_SMD] && avs_byteenable[0] |=> sys_gates.smd)
        else $error("modem set lost");

    smd_clr_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        wr_sysclr && avs_writedata[BIT_SMD] && avs_byteenable[0] |=> !sys_gates.smd)
        else $error("modem clear lost");

    uhp_pair_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        sys_gates.usb_host_48mhz == sys_gates.usb_host_12mhz)
        else $error("usb host clocks split");

    uhp_set_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        wr_sysset && avs_writedata[BIT_UHP] && avs_byteenable[0]
        |=> sys_gates.usb_host_48mhz && sys_gates.usb_host_12mhz)
        else $error("usb host set lost");

    uhp_clr_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        wr_sysclr && avs_writedata[BIT_UHP] && avs_byteenable[0]
        |=> !sys_gates.usb_host_48mhz && !sys_gates.usb_host_12mhz)
        else $error("usb host clear lost");

    udp_set_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        wr_sysset && avs_writedata[BIT_UDP] && avs_byteenable[0] |=> sys_gates.usb_dev)
        else $error("usb device set lost");

    udp_clr_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        wr_sysclr && avs_writedata[BIT_UDP] && avs_byteenable[0] |=> !sys_gates.usb_dev)
        else $error("usb device clear lost");

    prog0_set_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        wr_sysset && avs_writedata[BIT_PROG0] && avs_byteenable[1]
        |=> sys_gates.prog_out0)
        else $error("prog out0 set lost");

    prog0_clr_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        wr_sysclr && avs_writedata[BIT_PROG0] && avs_byteenable[1]
        |=> !sys_gates.prog_out0)
        else $error("prog out0 clear lost");

    prog1_set_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        wr_sysset && avs_writedata[BIT_PROG1] && avs_byteenable[1]
        |=> sys_gates.prog_out1)
        else $error("prog out1 set lost");

    prog1_clr_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        wr_sysclr && avs_writedata[BIT_PROG1] && avs_byteenable[1]
        |=> !sys_gates.prog_out1)
        else $error("prog out1 clear lost");

    cpu_noset_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        !sys_gates.cpu |=> !sys_gates.cpu)
        else $error("cpu clock restarted");

    cpu_clr_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        wr_sysclr && avs_writedata[BIT_CPU] && avs_byteenable[0] |=> !sys_gates.cpu)
        else $error("cpu clear lost");

    sys_zero_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (wr_sysset || wr_sysclr) && avs_writedata == RST_ZERO |=> $stable(sys_state_reg))
        else $error("zero write moved state");

    sys_bits_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        (sys_state_reg & ~SYS_CLR_MASK) == RST_ZERO)
        else $error("unused state bit set");

    per_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        !wr_perset && !wr_perclr |=> $stable(periph_clk_en))
        else $error("peripheral state moved");

    per_low_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        periph_clk_en[1:0] == 2'b00)
        else $error("unused ids set");

    per_set_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        wr_perset && avs_writedata[5] && avs_byteenable[0] && PERIPH_IMPL[5]
        |=> periph_clk_en[5])
        else $error("peripheral set lost");

    per_clr_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        wr_perclr && avs_writedata[5] && avs_byteenable[0] && PERIPH_IMPL[5]
        |=> !periph_clk_en[5])
        else $error("peripheral clear lost");

    per_keep_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        wr_perclr && !avs_writedata[9] |=> periph_clk_en[9] == $past(periph_clk_en[9]))
        else $error("peripheral clear spilled");

    per_unimpl_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        wr_perset || wr_perclr
        |=> ((periph_clk_en ^ $past(periph_clk_en)) & ~PERIPH_IMPL) == RST_ZERO)
        else $error("unimplemented id moved");

    sys_rst_a: assert property (@(posedge ref_clk)
        !resetn |=> sys_state_reg == RST_SYS_STATE)
        else $error("system state reset wrong");

    per_rst_a: assert property (@(posedge ref_clk)
        !resetn |=> per_state_reg == RST_PER_STATE)
        else $error("peripheral state reset wrong");

    prog_rst_a: assert property (@(posedge ref_clk)
        !resetn |=> prog0_reg == RST_ZERO && prog1_reg == RST_ZERO)
        else $error("prog config reset wrong");

    icp_rst_a: assert property (@(posedge ref_clk)
        !resetn |=> icp_reg == RST_PLL_ICP)
        else $error("charge pump reset wrong");

    wpm_rst_a: assert property (@(posedge ref_clk)
        !resetn |=> wpm_reg == RST_ZERO)
        else $error("protect mode reset wrong");

    smd_rst_a: assert property (@(posedge ref_clk)
        !resetn |=> smd_reg == RST_ZERO)
        else $error("modem config reset wrong");

    wo_read_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        rd_first && (avs_address == OFS_SYS_SET || avs_address == OFS_PER_CLR
                     || avs_address == OFS_PLL_ICP)
        |=> avs_readdata == RST_ZERO)
        else $error("write-only read nonzero");

    rsv_read_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        rd_first && avs_address == 8'h2c |=> avs_readdata == RST_ZERO)
        else $error("reserved read nonzero");

    freq_rd_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        rd_first && avs_address == OFS_MAIN_FREQ |=> avs_readdata == RST_ZERO)
        else $error("frequency read nonzero");

    wps_rd_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        rd_first && avs_address == OFS_WP_STATUS |=> avs_readdata == RST_ZERO)
        else $error("protect status nonzero");

    sys_rd_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        rd_first && avs_address == OFS_SYS_STATE |=> avs_readdata == $past(sys_state_reg))
        else $error("system state read wrong");

    state_rd_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        rd_first && avs_address == OFS_SYS_STATE
        |=> avs_readdata[BIT_PROG0] == $past(sys_gates.prog_out0)
            && avs_readdata[BIT_PROG1] == $past(sys_gates.prog_out1))
        else $error("state read mismatch");

    per_rd_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        rd_first && avs_address == OFS_PER_STATE |=> avs_readdata == $past(periph_clk_en))
        else $error("peripheral state read wrong");
endmodule // clkgate_regs
`default_nettype wire

//--- hw/clkgate_pkg.sv
// Purpose: constants and types for the clock gating register interface
// Assumes: 32-bit Avalon-MM slave, byte addresses, word aligned
package clkgate_pkg;
    localparam logic [7:0] OFS_SYS_SET    = 8'h00;
    localparam logic [7:0] OFS_SYS_CLR    = 8'h04;
    localparam logic [7:0] OFS_SYS_STATE  = 8'h08;
    localparam logic [7:0] OFS_PER_SET    = 8'h10;
    localparam logic [7:0] OFS_PER_CLR    = 8'h14;
    localparam logic [7:0] OFS_PER_STATE  = 8'h18;
    localparam logic [7:0] OFS_UTMI_CFG   = 8'h1c;
    localparam logic [7:0] OFS_MAIN_OSC   = 8'h20;
    localparam logic [7:0] OFS_MAIN_FREQ  = 8'h24;
    localparam logic [7:0] OFS_PLLA_CFG   = 8'h28;
    localparam logic [7:0] OFS_MCK_CFG    = 8'h30;
    localparam logic [7:0] OFS_USB_CFG    = 8'h38;
    localparam logic [7:0] OFS_SMD_CFG    = 8'h3c;
    localparam logic [7:0] OFS_PROG0_CFG  = 8'h40;
    localparam logic [7:0] OFS_PROG1_CFG  = 8'h44;
    localparam logic [7:0] OFS_IRQ_EN     = 8'h60;
    localparam logic [7:0] OFS_IRQ_DIS    = 8'h64;
    localparam logic [7:0] OFS_PWR_STATUS = 8'h68;
    localparam logic [7:0] OFS_IRQ_MASK   = 8'h6c;
    localparam logic [7:0] OFS_PLL_ICP    = 8'h80;
    localparam logic [7:0] OFS_WP_MODE    = 8'he4;
    localparam logic [7:0] OFS_WP_STATUS  = 8'he8;

    localparam int BIT_CPU   = 0;
    localparam int BIT_DDR   = 2;
    localparam int BIT_SMD   = 4;
    localparam int BIT_UHP   = 6;
    localparam int BIT_UDP   = 7;
    localparam int BIT_PROG0 = 8;
    localparam int BIT_PROG1 = 9;

    localparam logic [31:0] SYS_SET_MASK   = 32'h0000_03d4;
    localparam logic [31:0] SYS_CLR_MASK   = 32'h0000_03d5;
    localparam logic [31:0] PER_ID_MASK    = 32'hffff_fffc;
    localparam logic [31:0] RST_SYS_STATE  = 32'h0000_0005;
    localparam logic [31:0] RST_PER_STATE  = 32'h0000_0000;
    localparam logic [31:0] RST_UTMI_CFG   = 32'h1020_0000;
    localparam logic [31:0] RST_MAIN_OSC   = 32'h0100_0008;
    localparam logic [31:0] RST_PLLA_CFG   = 32'h0000_3f00;
    localparam logic [31:0] RST_MCK_CFG    = 32'h0000_0001;
    localparam logic [31:0] RST_PWR_STATUS = 32'h0001_0008;
    localparam logic [31:0] RST_PLL_ICP    = 32'h0100_0100;
    localparam logic [31:0] RST_ZERO       = 32'h0000_0000;

    typedef struct packed {
        logic        cpu;
        logic        ddr;
        logic        smd;
        logic        usb_host_48mhz;
        logic        usb_host_12mhz;
        logic        usb_dev;
        logic        prog_out0;
        logic        prog_out1;
    } clkgate_sys_gates_s;
endpackage : clkgate_pkg

//--- verif/clkgate_regs_bench.sv
// Purpose: self-checking bench for the clock gating register slave
// Assumes: Avalon-MM master holds each request until waitrequest is low
// Notes: an idle edge after each request keeps every input to one change per step
`timescale 1ns/100ps
`default_nettype none
module clkgate_regs_bench
    import clkgate_pkg::*;
;
    logic               ref_clk = 1'b0;
    logic               resetn;
    logic [7:0]         avs_address;
    logic               avs_read;
    logic               avs_write;
    logic [31:0]        avs_writedata;
    logic [3:0]         avs_byteenable;
    logic [31:0]        avs_readdata;
    logic               avs_waitrequest;
    logic [1:0]         avs_response;
    clkgate_sys_gates_s sys_gates;
    logic [31:0]        periph_clk_en;
    logic [31:0]        sys_exp;
    logic [31:0]        per_exp;
    logic [31:0]        q;
    int                 mismatches = 0;
    int                 checks = 0;
    int                 cycles = 0;
    int                 bl [6] = '{2, 4, 6, 7, 8, 9};
    logic [7:0]         ofs [13] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h80, 8'h2c, 8'h1c, 8'h20,
                                     8'h28, 8'h30, 8'h68, 8'h6c, 8'h38};
    logic [31:0]        rv [13] = '{0, 0, 0, 0, 0, 0, RST_UTMI_CFG, RST_MAIN_OSC,
                                    RST_PLLA_CFG, RST_MCK_CFG, RST_PWR_STATUS, 0, 0};
    logic [7:0]         rw [4] = '{OFS_SMD_CFG, OFS_PROG0_CFG, OFS_PROG1_CFG, OFS_WP_MODE};
    logic [7:0]         ro [7] = '{OFS_SYS_STATE, OFS_PER_STATE, OFS_MAIN_FREQ, OFS_WP_STATUS,
                                   OFS_PLL_ICP, 8'h2c, 8'hf0};

    clkgate_regs uut (
        .ref_clk         (ref_clk),
        .resetn          (resetn),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .avs_response    (avs_response),
        .sys_gates       (sys_gates),
        .periph_clk_en   (periph_clk_en)
    );

    initial
    begin
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic summarize();
        if (mismatches == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // cut a hang short; whole run needs well under this
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 4000)
        begin
            mismatches++;
            summarize();
        end
    end

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask

    // held until waitrequest seen low; data taken at that same edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge ref_clk);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk($sformatf("read %h", a), e, q);
    endtask

    function automatic clkgate_sys_gates_s gx(input logic [31:0] s);
        gx = {s[0], s[2], s[4], s[6], s[6], s[7], s[8], s[9]};
    endfunction

    task automatic state_chk();
        rd(OFS_SYS_STATE, sys_exp);
        rd(OFS_PER_STATE, per_exp);
        chk("sys_gates", {24'h0, gx(sys_exp)}, {24'h0, sys_gates});
        chk("periph_clk_en", per_exp, periph_clk_en);
    endtask

    initial
    begin
        resetn = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hf;
        sys_exp = 32'h0000_0005;
        per_exp = 32'h0000_0000;
        repeat (16) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        state_chk();
        for (int i = 0; i < 13; i++) rd(ofs[i], rv[i]);
        for (int i = 0; i < 4; i++) rd(rw[i], 32'h0000_0000);
        rd(OFS_MAIN_FREQ, 32'h0000_0000);
        for (int i = 0; i < 6; i++)
        begin
            bus(1'b1, OFS_SYS_SET, 32'h1 << bl[i]);
            sys_exp[bl[i]] = 1'b1;
            state_chk();
        end
        bus(1'b1, OFS_SYS_CLR, 32'h0000_0001);
        sys_exp[0] = 1'b0;
        state_chk();
        bus(1'b1, OFS_SYS_SET, 32'hffff_fc2b);
        bus(1'b1, OFS_SYS_CLR, 32'h0000_0000);
        state_chk();
        for (int i = 0; i < 6; i++)
        begin
            bus(1'b1, OFS_SYS_CLR, 32'h1 << bl[i]);
            sys_exp[bl[i]] = 1'b0;
            state_chk();
        end
        bus(1'b1, OFS_PER_SET, 32'hffff_ffff);
        per_exp = 32'hffff_fffc;
        state_chk();
        bus(1'b1, OFS_PER_CLR, 32'h0000_0110);
        bus(1'b1, OFS_PER_SET, 32'h0000_0000);
        per_exp = 32'hffff_feec;
        state_chk();
        for (int i = 0; i < 4; i++) bus(1'b1, rw[i], 32'ha5c3_0f96 ^ i);
        for (int i = 0; i < 7; i++) bus(1'b1, ro[i], 32'hffff_ffff);
        for (int i = 0; i < 4; i++) rd(rw[i], 32'ha5c3_0f96 ^ i);
        for (int i = 2; i < 7; i++) rd(ro[i], 32'h0000_0000);
        state_chk();
        // mid-run reset must bring every gate and the smd, prog and protect mode configs back
        resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        sys_exp = 32'h0000_0005;
        per_exp = 32'h0000_0000;
        state_chk();
        for (int i = 0; i < 4; i++) rd(rw[i], 32'h0000_0000);
        summarize();
    end
endmodule // clkgate_regs_bench
`default_nettype wire
